// file: design/cmsf_ctx_store.sv
// Context store for system management entry: holds flags word, mode and long-mode state.
// Assumes one writer on the processor clock; read data lag the store by one cycle.
`timescale 1ns/10ps

module cmsf_ctx_store #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Save side
  input wire logic save_en,
  input wire logic [WIDTH-1:0] save_flags,
  input wire cmsf_pkg::cmsf_mode_e save_mode,
  input wire logic save_long,
  // Registered read side
  output logic [WIDTH-1:0] rd_flags,
  output cmsf_pkg::cmsf_mode_e rd_mode,
  output logic rd_long
);
  import cmsf_pkg::*;

  logic [WIDTH-1:0] flags_mem_r;
  cmsf_mode_e mode_mem_r;
  logic long_mem_r;

  ////////////////////////////////////////////////////////////////////////////
  // Storage written once per entry
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_mem_r <= '0;
      mode_mem_r <= CMSF_MODE_REAL;
      long_mem_r <= 1'b0;
    end else if (save_en) begin
      flags_mem_r <= save_flags;
      mode_mem_r <= save_mode;
      long_mem_r <= save_long;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data from a register, so the restore path has no long combinational reach
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_flags <= '0;
      rd_mode <= CMSF_MODE_REAL;
      rd_long <= 1'b0;
    end else begin
      rd_flags <= flags_mem_r;
      rd_mode <= mode_mem_r;
      rd_long <= long_mem_r;
    end
  end

endmodule

// file: design/cmsf_defs.svh
// Bit positions, reset values, privilege codes and access sizes of the mode and flags block.
// Assumes that it is included by bare name wherever these constants are needed.
`ifndef CMSF_DEFS_SVH
`define CMSF_DEFS_SVH

// System flags word field positions
`define CMSF_STEP_BIT 8
`define CMSF_IRQEN_BIT 9
`define CMSF_IOPRIV_LO 12
`define CMSF_IOPRIV_HI 13
`define CMSF_NEST_BIT 14
`define CMSF_RESUME_BIT 16
`define CMSF_V86_BIT 17
`define CMSF_ALIGN_BIT 18
`define CMSF_VIRQ_BIT 19
`define CMSF_VPEND_BIT 20
`define CMSF_PROBE_BIT 21

// Extended feature enable register field positions
`define CMSF_XF_LMEN_BIT 8
`define CMSF_XF_LACT_BIT 10

// Reset values; all system flags start clear
`define CMSF_FLAGS_RESET 32'h0000_0000
`define CMSF_XF_RESET 32'h0000_0000

// Privilege levels
`define CMSF_PL_KERNEL 2'h0
`define CMSF_PL_USER 2'h3

// Access sizes on the memory check port
`define CMSF_SZ_WORD 2'h1
`define CMSF_SZ_DWORD 2'h2
`define CMSF_SZ_QWORD 2'h3

`endif

// file: design/cmsf_pkg.sv
// Types shared by the mode and flags block and its context store.
// Assumes nothing beyond a SystemVerilog compiler.
package cmsf_pkg;

  // Operating mode of the processor
  typedef enum logic [2:0] {
    CMSF_MODE_REAL,
    CMSF_MODE_PROT,
    CMSF_MODE_V86,
    CMSF_MODE_COMPAT,
    CMSF_MODE_LONG64,
    CMSF_MODE_MGMT
  } cmsf_mode_e;

  // Kind of instruction reported on completion
  typedef enum logic [2:0] {
    CMSF_INS_OTHER,
    CMSF_INS_FLAGS_POP,
    CMSF_INS_IRQ_RET,
    CMSF_INS_IRQ_DISABLE,
    CMSF_INS_IRQ_ENABLE,
    CMSF_INS_RESUME_MGMT,
    CMSF_INS_TASK_ENTRY
  } cmsf_instr_e;

endpackage

// file: design/cmsf_top.sv
// Operating-mode controller and system part of the flags word.
// Assumes all inputs except the management pin come from logic on clk.
`timescale 1ns/10ps
`include "cmsf_defs.svh"

module cmsf_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control bits from the control and feature registers
  input wire logic ctrl_prot_enable,
  input wire logic ctrl_paging_enable,
  input wire logic ctrl_align_mask,
  input wire logic ctrl_v86_ext_enable,
  input wire logic ctrl_prot_virq_enable,
  input wire logic xf_long_mode_enable,
  input wire logic code_seg_long_bit,
  input wire logic [1:0] cur_priv,
  // Management interrupt pin, active low, asynchronous
  input wire logic sys_mgmt_irq_pin_n,
  // Instruction completion
  input wire logic instr_done,
  input wire cmsf_pkg::cmsf_instr_e instr_kind,
  input wire logic [31:0] flags_wr_data,
  // Event checks
  input wire logic irq_request,
  input wire logic nmi_request,
  input wire logic instr_bkpt_hit,
  input wire logic io_access_req,
  input wire logic mem_access_req,
  input wire logic [2:0] mem_addr_low,
  input wire logic [1:0] mem_size,
  input wire logic mem_implicit_priv,
  // Mode and register state
  output cmsf_pkg::cmsf_mode_e cpu_mode,
  output logic [31:0] system_flags_word,
  output logic [31:0] xf_status_word,
  output logic mgmt_addr_space,
  // Event answers, registered one cycle after their request; virq_deliver is a level
  output logic irq_accept,
  output logic nmi_accept,
  output logic debug_exception,
  output logic io_grant,
  output logic io_fault,
  output logic align_fault,
  output logic general_protection_fault,
  output logic task_return,
  output logic virq_deliver
);
  import cmsf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  cmsf_mode_e mode_r;
  cmsf_mode_e mode_nxt;
  cmsf_mode_e ctx_mode;
  logic [31:0] flags_r;
  logic [31:0] ctx_flags;
  logic [31:0] xf_r;
  logic long_nxt;
  logic ctx_long;
  logic pin_sync1_r;
  logic pin_sync2_r;
  logic pin_prev_r;
  logic mgmt_edge;
  logic mgmt_enter;
  logic resume_fire;
  logic pop_or_ret;
  logic in_long;
  logic [1:0] io_priv;
  logic irqen_ok;
  logic v86_ext_path;
  logic virq_on;
  logic interrupt_return_instr_nest_fault;

  // Interrupt enable may be changed only at or above the I/O level
  function automatic logic irqen_change_ok(input logic [1:0] pl, input logic [1:0] iop);
    irqen_change_ok = (pl <= iop);
  endfunction

  // Word on odd byte, doubleword or quadword off its natural boundary
  function automatic logic misaligned(input logic [2:0] a, input logic [1:0] sz);
    case (sz)
      `CMSF_SZ_WORD: misaligned = a[0];
      `CMSF_SZ_DWORD: misaligned = |a[1:0];
      `CMSF_SZ_QWORD: misaligned = |a;
      default: misaligned = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Shared decode
  assign io_priv = flags_r[`CMSF_IOPRIV_HI:`CMSF_IOPRIV_LO];
  assign in_long = xf_r[`CMSF_XF_LACT_BIT];
  assign pop_or_ret = instr_done &&
                      (instr_kind == CMSF_INS_FLAGS_POP || instr_kind == CMSF_INS_IRQ_RET);
  assign resume_fire = instr_done && (instr_kind == CMSF_INS_RESUME_MGMT) &&
                       (mode_r == CMSF_MODE_MGMT);
  assign irqen_ok = irqen_change_ok(cur_priv, io_priv);
  assign v86_ext_path = (mode_r == CMSF_MODE_V86) && ctrl_v86_ext_enable &&
                        (io_priv != `CMSF_PL_USER);
  assign virq_on = (ctrl_v86_ext_enable || ctrl_prot_virq_enable) &&
                   (io_priv != `CMSF_PL_USER);
  assign interrupt_return_instr_nest_fault = instr_done && (instr_kind == CMSF_INS_IRQ_RET) && in_long &&
                           flags_r[`CMSF_NEST_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Management pin synchroniser; only the second stage feeds the edge detect
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_sync1_r <= 1'b1;
      pin_sync2_r <= 1'b1;
      pin_prev_r <= 1'b1;
    end else begin
      pin_sync1_r <= sys_mgmt_irq_pin_n;
      pin_sync2_r <= pin_sync1_r;
      pin_prev_r <= pin_sync2_r;
    end
  end

  // A falling edge requests entry; edges seen while already inside are dropped
  assign mgmt_edge = pin_prev_r && !pin_sync2_r;
  assign mgmt_enter = mgmt_edge && (mode_r != CMSF_MODE_MGMT);

  ////////////////////////////////////////////////////////////////////////////
  // Long mode activity: entered only from protected mode with paging and enable
  always_comb begin
    long_nxt = ctrl_prot_enable && ctrl_paging_enable && xf_long_mode_enable &&
               (mode_r == CMSF_MODE_PROT || in_long);
  end

  // Next operating mode; management mode wins over every other indication
  always_comb begin
    mode_nxt = mode_r;
    if (mgmt_enter) begin
      mode_nxt = CMSF_MODE_MGMT;
    end else if (mode_r == CMSF_MODE_MGMT) begin
      if (resume_fire) begin
        mode_nxt = ctx_mode;
      end else begin
        mode_nxt = CMSF_MODE_MGMT;
      end
    end else if (!ctrl_prot_enable) begin
      mode_nxt = CMSF_MODE_REAL;
    end else if (long_nxt) begin
      mode_nxt = code_seg_long_bit ? CMSF_MODE_LONG64 : CMSF_MODE_COMPAT;
    end else if (flags_r[`CMSF_V86_BIT]) begin
      mode_nxt = CMSF_MODE_V86;
    end else begin
      mode_nxt = CMSF_MODE_PROT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_r <= CMSF_MODE_REAL;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Feature register: enable mirrors the control, activity tracks the mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xf_r <= `CMSF_XF_RESET;
    end else begin
      xf_r[`CMSF_XF_LMEN_BIT] <= xf_long_mode_enable;
      if (mgmt_enter) begin
        xf_r[`CMSF_XF_LACT_BIT] <= in_long;
      end else if (mode_r == CMSF_MODE_MGMT) begin
        if (resume_fire) begin
          xf_r[`CMSF_XF_LACT_BIT] <= ctx_long;
        end
      end else begin
        xf_r[`CMSF_XF_LACT_BIT] <= long_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Saved context for the management excursion
  cmsf_ctx_store #(
    .WIDTH(32)
  ) u_ctx (
    .clk(clk),
    .sys_rst(sys_rst),
    .save_en(mgmt_enter),
    .save_flags(flags_r),
    .save_mode(mode_r),
    .save_long(in_long),
    .rd_flags(ctx_flags),
    .rd_mode(ctx_mode),
    .rd_long(ctx_long)
  );

  // Separate address space select follows the mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mgmt_addr_space <= 1'b0;
    end else begin
      mgmt_addr_space <= (mode_nxt == CMSF_MODE_MGMT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System flags. The pending bit moves only on a software load, never by itself.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_r <= `CMSF_FLAGS_RESET;
    end else if (resume_fire) begin
      flags_r <= ctx_flags;
    end else if (instr_done) begin
      case (instr_kind)
        CMSF_INS_FLAGS_POP, CMSF_INS_IRQ_RET: begin
          if (!interrupt_return_instr_nest_fault) begin
            // New step value only counts from the next completion onward
            flags_r[`CMSF_STEP_BIT] <= flags_wr_data[`CMSF_STEP_BIT];
            flags_r[`CMSF_NEST_BIT] <= flags_wr_data[`CMSF_NEST_BIT];
            flags_r[`CMSF_RESUME_BIT] <= flags_wr_data[`CMSF_RESUME_BIT];
            flags_r[`CMSF_ALIGN_BIT] <= flags_wr_data[`CMSF_ALIGN_BIT];
            flags_r[`CMSF_VPEND_BIT] <= flags_wr_data[`CMSF_VPEND_BIT];
            flags_r[`CMSF_PROBE_BIT] <= flags_wr_data[`CMSF_PROBE_BIT];
            flags_r[`CMSF_VIRQ_BIT] <= flags_wr_data[`CMSF_VIRQ_BIT];
            if (cur_priv == `CMSF_PL_KERNEL) begin
              flags_r[`CMSF_IOPRIV_HI:`CMSF_IOPRIV_LO] <=
                flags_wr_data[`CMSF_IOPRIV_HI:`CMSF_IOPRIV_LO];
            end
            if (irqen_ok) begin
              flags_r[`CMSF_IRQEN_BIT] <= flags_wr_data[`CMSF_IRQEN_BIT];
            end else if (v86_ext_path) begin
              flags_r[`CMSF_VIRQ_BIT] <= flags_wr_data[`CMSF_IRQEN_BIT];
            end
            // Only a return may switch into v86; long mode ignores the attempt
            if (instr_kind == CMSF_INS_IRQ_RET && !in_long) begin
              flags_r[`CMSF_V86_BIT] <= flags_wr_data[`CMSF_V86_BIT];
            end
          end
        end
        CMSF_INS_IRQ_DISABLE, CMSF_INS_IRQ_ENABLE: begin
          if (irqen_ok) begin
            flags_r[`CMSF_IRQEN_BIT] <= (instr_kind == CMSF_INS_IRQ_ENABLE);
          end else if (v86_ext_path) begin
            flags_r[`CMSF_VIRQ_BIT] <= (instr_kind == CMSF_INS_IRQ_ENABLE);
          end
          flags_r[`CMSF_RESUME_BIT] <= 1'b0;
        end
        CMSF_INS_TASK_ENTRY: begin
          if (!in_long) begin
            flags_r[`CMSF_NEST_BIT] <= 1'b1;
          end
          flags_r[`CMSF_RESUME_BIT] <= 1'b0;
        end
        default: begin
          flags_r[`CMSF_RESUME_BIT] <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protection fault for denied enable changes and nested return in long mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      general_protection_fault <= 1'b0;
    end else begin
      general_protection_fault <= interrupt_return_instr_nest_fault ||
        (instr_done && !irqen_ok && !v86_ext_path && (mode_r != CMSF_MODE_REAL) &&
         (instr_kind == CMSF_INS_IRQ_DISABLE || instr_kind == CMSF_INS_IRQ_ENABLE));
    end
  end

  // Task return is signalled when a return finds the nested flag outside long mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      task_return <= 1'b0;
    end else begin
      task_return <= instr_done && (instr_kind == CMSF_INS_IRQ_RET) && !in_long &&
                     flags_r[`CMSF_NEST_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt gating: the enable flag never touches nonmaskable requests
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_accept <= 1'b0;
      nmi_accept <= 1'b0;
      virq_deliver <= 1'b0;
    end else begin
      irq_accept <= irq_request && flags_r[`CMSF_IRQEN_BIT];
      nmi_accept <= nmi_request;
      virq_deliver <= virq_on && flags_r[`CMSF_VIRQ_BIT] && flags_r[`CMSF_VPEND_BIT];
    end
  end

  // Debug exceptions: step trap on completion, breakpoints masked by resume flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      debug_exception <= 1'b0;
    end else begin
      debug_exception <= (instr_done && flags_r[`CMSF_STEP_BIT]) ||
                         (instr_bkpt_hit && !flags_r[`CMSF_RESUME_BIT]);
    end
  end

  // I/O permission check against the current privilege
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_grant <= 1'b0;
      io_fault <= 1'b0;
    end else begin
      io_grant <= io_access_req && (cur_priv <= io_priv);
      io_fault <= io_access_req && (cur_priv > io_priv);
    end
  end

  // Alignment check, user level and explicit references only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      align_fault <= 1'b0;
    end else begin
      align_fault <= mem_access_req && flags_r[`CMSF_ALIGN_BIT] && ctrl_align_mask &&
                     (cur_priv == `CMSF_PL_USER) && !mem_implicit_priv &&
                     misaligned(mem_addr_low, mem_size);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign cpu_mode = mode_r;
  assign system_flags_word = flags_r;
  assign xf_status_word = xf_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_reset_real_mode:
  assert property (disable iff (1'b0) sys_rst |=> mode_r == CMSF_MODE_REAL)
    else $error("mode not real after reset");

  a_pe_clear_real:
  assert property ((mode_r != CMSF_MODE_MGMT) && !mgmt_edge && !ctrl_prot_enable
                   |=> mode_r == CMSF_MODE_REAL)
    else $error("real mode not taken with protection off");

  a_v86_select_mode:
  assert property ((mode_r == CMSF_MODE_PROT) && !mgmt_edge && ctrl_prot_enable &&
                   !xf_long_mode_enable && flags_r[`CMSF_V86_BIT] |=> mode_r == CMSF_MODE_V86)
    else $error("v86 mode not entered");

  a_long_bit_report:
  assert property ((mode_r == CMSF_MODE_COMPAT || mode_r == CMSF_MODE_LONG64)
                   |-> xf_status_word[`CMSF_XF_LACT_BIT])
    else $error("long mode without activity bit");

  a_long_sub_mode:
  assert property ((mode_r != CMSF_MODE_MGMT) ##1 (mode_r == CMSF_MODE_LONG64)
                   |-> $past(code_seg_long_bit))
    else $error("64-bit sub-mode without long code segment");

  a_long_entry_cond:
  assert property ($rose(in_long) && $past(mode_r) != CMSF_MODE_MGMT
                   |-> $past(ctrl_paging_enable && xf_long_mode_enable) &&
                       $past(mode_r) == CMSF_MODE_PROT)
    else $error("long mode entered without paging and enable");

  a_mgmt_entry_save:
  assert property (mgmt_enter |=> (mode_r == CMSF_MODE_MGMT && mgmt_addr_space) ##2
                   (mode_r != CMSF_MODE_MGMT || ctx_flags == $past(flags_r, 3)))
    else $error("management entry or context save failed");

  a_mgmt_restore_exact:
  assert property (resume_fire |=> mode_r == $past(ctx_mode) && flags_r == $past(ctx_flags))
    else $error("resume did not restore context");

  a_step_next_instr:
  assert property (instr_done && instr_kind == CMSF_INS_FLAGS_POP &&
                   !flags_r[`CMSF_STEP_BIT] && !instr_bkpt_hit |=> !debug_exception)
    else $error("step trap after the setting instruction");

  a_irq_gate_flag:
  assert property (irq_accept |-> $past(flags_r[`CMSF_IRQEN_BIT]) && $past(irq_request))
    else $error("maskable interrupt accepted while disabled");

  a_io_priv_check:
  assert property (io_access_req |=> io_grant == ($past(cur_priv) <= $past(io_priv)) &&
                   io_fault != io_grant)
    else $error("I/O permission answer wrong");

  a_vpend_hw_hold:
  assert property (!pop_or_ret && !resume_fire |=> $stable(flags_r[`CMSF_VPEND_BIT]))
    else $error("pending flag changed by hardware");

  a_long_nest_fault:
  assert property (interrupt_return_instr_nest_fault |=> general_protection_fault && $stable(flags_r))
    else $error("nested return in long mode not faulted");

  a_mgmt_holds_mode:
  assert property ((mode_r == CMSF_MODE_MGMT) && !resume_fire |=> mode_r == CMSF_MODE_MGMT)
    else $error("management mode left without resume");

endmodule

// file: verif/cmsf_mgmt_src.sv
// System logic that raises the management interrupt pin.
// Assumes the bench pulses go for one cycle, never while reset is held.
`timescale 1ns/10ps

module cmsf_mgmt_src (
  // Clock and bench request
  input wire logic clk,
  input wire logic go,
  input wire logic [3:0] lag,
  // Management pin, active low, idle high
  output logic pin_n
);
  initial pin_n = 1'b1;
  // Answers after lag cycles; holds low past the synchroniser so the edge is seen
  always @(posedge go) begin
    repeat (lag) @(negedge clk);
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    pin_n <= 1'b1;
  end
endmodule

// file: verif/tb.sv
// Self-checking bench for the mode and flags block with a management pin source.
// Assumes the design files and cmsf_defs.svh are on the include path.
`timescale 1ns/10ps
`include "cmsf_defs.svh"

module tb;
  import cmsf_pkg::*;
  logic clk, sys_rst, pe, pg, am, v86_extensions_enable, protected_virtual_irq_enable, long_mode_enable, csl, pin_n, go, done, imp, t_done, live;
  logic mas, act;
  logic [4:0] rq;
  logic [3:0] lag;
  logic [1:0] current_privilege_level, msz;
  logic [2:0] madr, em;
  logic [31:0] wd, rnd, flw, d, xfw;
  logic [8:0] ev;
  cmsf_instr_e kind;
  cmsf_mode_e mode, last_mode;
  int failures, cmp_count;
  logic [31:0] flq[$];
  logic [8:0] evq[$];
  logic [2:0] mq[$];

  cmsf_top dut_u (.clk(clk), .sys_rst(sys_rst), .ctrl_prot_enable(pe), .ctrl_paging_enable(pg),
    .ctrl_align_mask(am), .ctrl_v86_ext_enable(v86_extensions_enable), .ctrl_prot_virq_enable(protected_virtual_irq_enable),
    .xf_long_mode_enable(long_mode_enable), .code_seg_long_bit(csl), .cur_priv(current_privilege_level),
    .sys_mgmt_irq_pin_n(pin_n), .instr_done(done), .instr_kind(kind), .flags_wr_data(wd),
    .irq_request(rq[4]), .nmi_request(rq[3]), .io_access_req(rq[2]), .mem_access_req(rq[1]),
    .instr_bkpt_hit(rq[0]), .mem_addr_low(madr), .mem_size(msz), .mem_implicit_priv(imp),
    .cpu_mode(mode), .system_flags_word(flw), .xf_status_word(xfw), .mgmt_addr_space(mas),
    .irq_accept(ev[8]), .nmi_accept(ev[7]), .debug_exception(ev[6]), .io_grant(ev[5]),
    .io_fault(ev[4]), .align_fault(ev[3]), .general_protection_fault(ev[2]),
    .task_return(ev[1]), .virq_deliver(ev[0]));
  cmsf_mgmt_src src_u (.clk(clk), .go(go), .lag(lag), .pin_n(pin_n));

  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic bad(string n, logic [31:0] e, logic [31:0] g);
    failures++;
    $display("ERROR %s expected %h seen %h", n, e, g);
  endtask
  task automatic chk_flags(logic [31:0] e);
    cmp_count++;
    if (flw !== e) bad("flags", e, flw);
  endtask
  task automatic chk_evt(logic [8:0] e);
    cmp_count++;
    if (ev !== e) bad("events", 32'(e), 32'(ev));
  endtask
  task automatic chk_mode(logic [2:0] e);
    cmp_count++;
    if (mode !== e) bad("mode", 32'(e), 32'(mode));
  endtask
  task automatic chk_xf(logic [31:0] e, logic s);
    cmp_count++;
    if (xfw !== e) bad("status word", e, xfw);
    if (mas !== s) bad("address space", 32'(s), 32'(mas));
  endtask

  task test_done;
    failures += flq.size() + evq.size() + mq.size();
    $display("Comparisons %0d, failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One completion; notes its flags image and any pulse it causes
  task automatic ins(cmsf_instr_e k, logic [31:0] dat, logic [31:0] f, logic [8:0] e);
    @(negedge clk);
    done = 1'b1;
    kind = k;
    wd = dat;
    flq.push_back(f);
    if (e != 9'h0) evq.push_back(e);
    @(negedge clk);
    done = 1'b0;
  endtask
  // One-cycle check request; an empty note means no pulse may appear
  task automatic req(logic [4:0] r, logic [8:0] e);
    @(negedge clk);
    rq = r;
    if (e != 9'h0) evq.push_back(e);
    @(negedge clk);
    rq = 5'h0;
  endtask
  // One-cycle virtual interrupt enable, so a delivery shows as a single pulse
  task automatic virq(logic [8:0] e);
    @(negedge clk);
    protected_virtual_irq_enable = 1'b1;
    if (e != 9'h0) evq.push_back(e);
    @(negedge clk);
    protected_virtual_irq_enable = 1'b0;
  endtask

  // Scoreboard: an unexpected result meets an unknown note and fails
  always @(posedge clk) begin
    t_done = done;
    #1;
    if (live && t_done) chk_flags(flq.size() ? flq.pop_front() : 32'hx);
    if (live && ev !== 9'h0) chk_evt(evq.size() ? evq.pop_front() : 9'hx);
    // Activity survives a management excursion; the enable mirror is cleared by reset
    if (live && mode !== last_mode) begin
      em = mq.size() ? mq.pop_front() : 3'hx;
      act = (em == CMSF_MODE_COMPAT || em == CMSF_MODE_LONG64) || (em == CMSF_MODE_MGMT &&
            (last_mode == CMSF_MODE_COMPAT || last_mode == CMSF_MODE_LONG64));
      chk_mode(em);
      chk_xf({21'h0, act, 1'b0, long_mode_enable && !sys_rst, 8'h0}, em == CMSF_MODE_MGMT);
      last_mode = mode;
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cut a hang short; the sequence needs well under 500 cycles
  initial begin
    #20000;
    failures++;
    test_done;
  end

  initial begin
    {pe, pg, am, v86_extensions_enable, protected_virtual_irq_enable, long_mode_enable, csl, go, done, imp, live, rq, lag} = '0;
    {current_privilege_level, msz, madr, wd, rnd} = {7'h0, 32'h0, 32'h9ae0};
    kind = CMSF_INS_OTHER;
    last_mode = CMSF_MODE_REAL;
    sys_rst = 1'b1;
    {failures, cmp_count} = '0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    {sys_rst, live} = 2'b01;
    // Random images in real mode, then interrupt and I/O checks
    for (int i = 0; i < 4; i++) begin
      rnd = xs(rnd);
      d = rnd & 32'h003c_7200;
      ins(CMSF_INS_FLAGS_POP, rnd & 32'hfffe_feff, d, 9'h0);
      req(5'h18, {d[9], 8'h80});
      current_privilege_level = `CMSF_PL_USER;
      req(5'h04, (d[13:12] == 2'h3) ? 9'h020 : 9'h010);
      current_privilege_level = `CMSF_PL_KERNEL;
      virq((d[20:19] == 2'h3 && d[13:12] != 2'h3) ? 9'h001 : 9'h0);
    end
    // Virtual delivery blocked at I/O level 3, allowed below it
    ins(CMSF_INS_FLAGS_POP, 32'h18_3000, 32'h18_3000, 9'h0);
    virq(9'h0);
    ins(CMSF_INS_FLAGS_POP, 32'h18_0000, 32'h18_0000, 9'h0);
    virq(9'h001);
    // Step armed by a pop traps only after the next instruction
    ins(CMSF_INS_FLAGS_POP, 32'h100, 32'h100, 9'h0);
    ins(CMSF_INS_OTHER, 32'h0, 32'h100, 9'h040);
    ins(CMSF_INS_FLAGS_POP, 32'h1_0000, 32'h1_0000, 9'h040);
    req(5'h01, 9'h0);
    ins(CMSF_INS_OTHER, 32'h0, 32'h0, 9'h0);
    req(5'h01, 9'h040);
    // Alignment needs both enables, user level, explicit misaligned access
    ins(CMSF_INS_FLAGS_POP, 32'h4_0000, 32'h4_0000, 9'h0);
    {am, current_privilege_level, madr, msz} = {1'b1, `CMSF_PL_USER, 3'h1, `CMSF_SZ_WORD};
    req(5'h02, 9'h008);
    imp = 1'b1;
    req(5'h02, 9'h0);
    {imp, madr, msz} = {1'b0, 3'h4, `CMSF_SZ_DWORD};
    req(5'h02, 9'h0);
    madr = 3'h2;
    req(5'h02, 9'h008);
    current_privilege_level = `CMSF_PL_KERNEL;
    req(5'h02, 9'h0);
    // Protected mode, refusals, nesting and virtual-8086
    ins(CMSF_INS_FLAGS_POP, 32'h0, 32'h0, 9'h0);
    mq.push_back(CMSF_MODE_PROT);
    pe = 1'b1;
    current_privilege_level = `CMSF_PL_USER;
    ins(CMSF_INS_IRQ_DISABLE, 32'h0, 32'h0, 9'h004);
    current_privilege_level = `CMSF_PL_KERNEL;
    ins(CMSF_INS_TASK_ENTRY, 32'h0, 32'h4000, 9'h0);
    ins(CMSF_INS_IRQ_ENABLE, 32'h0, 32'h4200, 9'h0);
    mq.push_back(CMSF_MODE_V86);
    ins(CMSF_INS_IRQ_RET, 32'h2_0000, 32'h2_0000, 9'h002);
    mq.push_back(CMSF_MODE_PROT);
    ins(CMSF_INS_IRQ_RET, 32'h0, 32'h0, 9'h0);
    // Long mode entry, sub-modes and its flag limits
    mq.push_back(CMSF_MODE_LONG64);
    @(negedge clk);
    {pg, long_mode_enable, csl} = 3'h7;
    repeat (3) @(negedge clk);
    mq.push_back(CMSF_MODE_COMPAT);
    csl = 1'b0;
    ins(CMSF_INS_IRQ_RET, 32'h2_0000, 32'h0, 9'h0);
    ins(CMSF_INS_TASK_ENTRY, 32'h0, 32'h0, 9'h0);
    ins(CMSF_INS_FLAGS_POP, 32'h4000, 32'h4000, 9'h0);
    ins(CMSF_INS_IRQ_RET, 32'h0, 32'h4000, 9'h004);
    // Management entry, mode controls frozen, exact return
    mq.push_back(CMSF_MODE_MGMT);
    @(negedge clk);
    {lag, go} = {rnd[3:0], 1'b1};
    @(negedge clk);
    go = 1'b0;
    repeat (lag + 8) @(negedge clk);
    {pe, csl} = 2'h1;
    ins(CMSF_INS_FLAGS_POP, 32'h0, 32'h0, 9'h0);
    {pe, csl} = 2'h2;
    mq.push_back(CMSF_MODE_COMPAT);
    ins(CMSF_INS_RESUME_MGMT, 32'h0, 32'h4000, 9'h0);
    // Second reset in mid-run
    mq.push_back(CMSF_MODE_REAL);
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    // Controls still on: protected mode first, then long mode from it
    mq.push_back(CMSF_MODE_PROT);
    mq.push_back(CMSF_MODE_COMPAT);
    repeat (4) @(negedge clk);
    test_done;
  end
endmodule
